// [lcdc_pkg.sv]
package lcdc_pkg;

	// i/o register byte addresses
	localparam logic [15:0] LCDC_OFS_POWER_DUTY = 16'hff60;
	localparam logic [15:0] LCDC_OFS_DISP_MODE = 16'hff61;
	localparam logic [15:0] LCDC_OFS_CONTRAST = 16'hff62;

	// display memory F000..F2FF (768 words): top six address bits select F000..F3FF
	localparam logic [5:0] LCDC_DMEM_TOP = 6'h3c;
	localparam int LCDC_DMEM_WORDS = 768;

	// field positions in lcd_power_duty_ctrl
	localparam int LCDC_POWER_BIT = 0;
	localparam int LCDC_REF_BIT = 1;
	localparam int LCDC_DUTY_LO_BIT = 2;
	localparam int LCDC_DUTY_HI_BIT = 3;
	// field positions in lcd_display_mode_ctrl
	localparam int LCDC_PAGE_BIT = 0;
	localparam int LCDC_ALL_ON_BIT = 1;
	localparam int LCDC_ALL_OFF_BIT = 2;
	localparam int LCDC_EXP_BIT = 3;

	// values after reset
	localparam logic [3:0] LCDC_RST_POWER_DUTY = 4'h0;
	localparam logic [3:0] LCDC_RST_DISP_MODE = 4'h4;

	// scan geometry
	localparam int LCDC_SEGS = 60;
	localparam int LCDC_COMS = 17;
	localparam logic [4:0] LCDC_LAST_COM_8 = 5'h07;
	localparam logic [4:0] LCDC_LAST_COM_16 = 5'h0f;
	localparam logic [4:0] LCDC_LAST_COM_17 = 5'h10;

	// timing: low-speed oscillator ticks per common slot
	localparam int LCDC_CLK_HZ = 200000000;
	localparam int LCDC_LOW_OSC_HZ = 32768;
	localparam int LCDC_OSC_DIV = LCDC_CLK_HZ / LCDC_LOW_OSC_HZ;
	localparam logic [6:0] LCDC_SLOT_LAST_8 = 7'h7f;
	localparam logic [6:0] LCDC_SLOT_LAST_16 = 7'h3f;
	localparam int LCDC_SETTLE_MS = 100;

	typedef enum logic [1:0] {
		LCDC_DUTY_17 = 2'b00,
		LCDC_DUTY_16 = 2'b01,
		LCDC_DUTY_8 = 2'b10
	} lcdc_duty_e;

	typedef struct packed {
		logic [15:0] addr;
		logic wr;
		logic rd;
		logic [3:0] wdata;
	} lcdc_bus_s;

	typedef struct packed {
		logic power;
		logic ref_sel;
		logic contrast_en;
		logic [3:0] contrast;
		logic exp_en;
	} lcdc_drive_s;

	typedef struct packed {
		logic [3:0] power_duty;
		logic [3:0] disp_mode;
		logic [3:0] contrast;
		logic [4:0] com_idx;
		logic [6:0] slot_cnt;
		logic [LCDC_COMS-1:0] com;
		logic [LCDC_SEGS-1:0] seg;
		logic [3:0] rdata;
		logic contrast_en;
	} lcdc_state_s;

endpackage

// [lcdc_tick_div.sv]
`timescale 1ns/1ps
module lcdc_tick_div #(
	parameter int DIV = 6103
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// one-cycle enable every DIV clocks
	output logic tick
);
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic nxt_tick;

	if (DIV < 2 || DIV > 65535) begin : g_bad_div
		$error("lcdc_tick_div: DIV out of range");
	end

	always_comb begin
		nxt_tick = (cnt_ff == 16'(DIV - 1));
		nxt_cnt = nxt_tick ? 16'h0000 : cnt_ff + 16'h0001;
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			cnt_ff <= 16'h0000;
			tick <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick <= nxt_tick;
		end
	end
endmodule // lcdc_tick_div

// [lcdc_ctrl.sv]
// Functional notes
// - power bit enables drive, else grounded
// - reference select picks level two or one
// - duty field picks 8, 16 or 17 commons
// - all-on lights every segment, memory untouched
// - all-off blanks every segment, memory untouched
// - all-on wins over all-off
// - reset sets all-off, clears power
// - page bit picks second screen at 1/8
// - page bit plain storage at 1/16, 1/17
// - contrast code gives 16 levels, light to dark
// - external supply disables contrast code
// - contrast and display memory not reset
// - expanded driver enable, resets to zero
// - power, reference, duty, all-on, page reset zero
// - memory bit one lights its dot
// - at 1/8 only commons 0..7 scanned
`timescale 1ns/1ps
module lcdc_ctrl #(
	parameter int OSC_DIV = lcdc_pkg::LCDC_OSC_DIV
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// cpu i/o memory access
	input wire lcdc_pkg::lcdc_bus_s bus,
	output logic [3:0] rdata,
	// manufacturing option: drive levels from outside
	input wire logic ext_supply,
	// analog drive control
	output lcdc_pkg::lcdc_drive_s drive,
	// panel lines: 1 = selected common / on waveform
	output logic [lcdc_pkg::LCDC_COMS-1:0] com_sel,
	output logic [lcdc_pkg::LCDC_SEGS-1:0] seg_on
);
	lcdc_pkg::lcdc_state_s st_ff;
	lcdc_pkg::lcdc_state_s nxt_st;
	logic [3:0] dmem [0:lcdc_pkg::LCDC_DMEM_WORDS-1];
	logic osc_tick;
	logic dmem_hit;
	lcdc_pkg::lcdc_duty_e duty;
	logic [4:0] last_com;
	logic [6:0] slot_last;
	logic [1:0] page_sel;
	logic [lcdc_pkg::LCDC_SEGS-1:0] mem_seg;

	lcdc_tick_div #(
		.DIV(OSC_DIV)
	) u_osc_div (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.tick(osc_tick)
	);

	assign dmem_hit = (bus.addr[15:10] == lcdc_pkg::LCDC_DMEM_TOP) && (bus.addr[9:8] != 2'b11);

	always_comb begin
		// upper duty bit alone forces 1/8
		if (st_ff.power_duty[lcdc_pkg::LCDC_DUTY_HI_BIT]) begin
			duty = lcdc_pkg::LCDC_DUTY_8;
			last_com = lcdc_pkg::LCDC_LAST_COM_8;
			slot_last = lcdc_pkg::LCDC_SLOT_LAST_8;
		end else if (st_ff.power_duty[lcdc_pkg::LCDC_DUTY_LO_BIT]) begin
			duty = lcdc_pkg::LCDC_DUTY_16;
			last_com = lcdc_pkg::LCDC_LAST_COM_16;
			slot_last = lcdc_pkg::LCDC_SLOT_LAST_16;
		end else begin
			duty = lcdc_pkg::LCDC_DUTY_17;
			last_com = lcdc_pkg::LCDC_LAST_COM_17;
			slot_last = lcdc_pkg::LCDC_SLOT_LAST_16;
		end
		// page only matters at 1/8; otherwise it is a plain stored bit
		case (duty)
			lcdc_pkg::LCDC_DUTY_8: begin
				page_sel = {1'b0, st_ff.disp_mode[lcdc_pkg::LCDC_PAGE_BIT]};
			end
			default: begin
				if (st_ff.com_idx == lcdc_pkg::LCDC_LAST_COM_17) begin
					page_sel = 2'b10;
				end else begin
					page_sel = {1'b0, st_ff.com_idx[3]};
				end
			end
		endcase
	end

	// word = page, segment, common group; bit = common within group; common 16 uses D0
	for (genvar s = 0; s < lcdc_pkg::LCDC_SEGS; s++) begin : g_seg
		logic [9:0] widx;
		logic [1:0] bsel;
		always_comb begin
			if (page_sel == 2'b10) begin
				widx = {page_sel, 7'(s), 1'b0};
				bsel = 2'b00;
			end else begin
				widx = {page_sel, 7'(s), st_ff.com_idx[2]};
				bsel = st_ff.com_idx[1:0];
			end
			mem_seg[s] = dmem[widx][bsel];
		end
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdata = 4'h0;
		nxt_st.contrast_en = !ext_supply;
		if (bus.wr) begin
			case (bus.addr)
				lcdc_pkg::LCDC_OFS_POWER_DUTY: nxt_st.power_duty = bus.wdata;
				lcdc_pkg::LCDC_OFS_DISP_MODE: nxt_st.disp_mode = bus.wdata;
				lcdc_pkg::LCDC_OFS_CONTRAST: nxt_st.contrast = bus.wdata;
				default: ;
			endcase
		end
		if (bus.rd) begin
			case (bus.addr)
				lcdc_pkg::LCDC_OFS_POWER_DUTY: nxt_st.rdata = st_ff.power_duty;
				lcdc_pkg::LCDC_OFS_DISP_MODE: nxt_st.rdata = st_ff.disp_mode;
				lcdc_pkg::LCDC_OFS_CONTRAST: nxt_st.rdata = st_ff.contrast;
				default: nxt_st.rdata = dmem_hit ? dmem[bus.addr[9:0]] : 4'h0;
			endcase
		end
		// step commons in order; an index left past a shortened duty wraps at once
		if (st_ff.com_idx > last_com) begin
			nxt_st.com_idx = 5'h00;
			nxt_st.slot_cnt = 7'h00;
		end else if (osc_tick) begin
			if (st_ff.slot_cnt >= slot_last) begin
				nxt_st.slot_cnt = 7'h00;
				nxt_st.com_idx = (st_ff.com_idx == last_com) ? 5'h00 : st_ff.com_idx + 5'h01;
			end else begin
				nxt_st.slot_cnt = st_ff.slot_cnt + 7'h01;
			end
		end
		if (!st_ff.power_duty[lcdc_pkg::LCDC_POWER_BIT]) begin
			nxt_st.com = '0;
			nxt_st.seg = '0;
		end else begin
			nxt_st.com = '0;
			// an index left above a shortened duty selects nothing while it wraps
			if (st_ff.com_idx <= last_com) begin
				nxt_st.com[st_ff.com_idx] = 1'b1;
			end
			if (st_ff.disp_mode[lcdc_pkg::LCDC_ALL_ON_BIT]) begin
				nxt_st.seg = '1;
			end else if (st_ff.disp_mode[lcdc_pkg::LCDC_ALL_OFF_BIT]) begin
				nxt_st.seg = '0;
			end else begin
				nxt_st.seg = mem_seg;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			st_ff.power_duty <= lcdc_pkg::LCDC_RST_POWER_DUTY;
			st_ff.disp_mode <= lcdc_pkg::LCDC_RST_DISP_MODE;
			st_ff.contrast <= nxt_st.contrast;
			st_ff.com_idx <= 5'h00;
			st_ff.slot_cnt <= 7'h00;
			st_ff.com <= '0;
			st_ff.seg <= '0;
			st_ff.rdata <= 4'h0;
			st_ff.contrast_en <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// display memory keeps its contents through reset
	always_ff @(posedge core_clk) begin
		if (bus.wr && dmem_hit) begin
			dmem[bus.addr[9:0]] <= bus.wdata;
		end
	end

	assign rdata = st_ff.rdata;
	assign com_sel = st_ff.com;
	assign seg_on = st_ff.seg;
	assign drive.power = st_ff.power_duty[lcdc_pkg::LCDC_POWER_BIT];
	assign drive.ref_sel = st_ff.power_duty[lcdc_pkg::LCDC_REF_BIT];
	assign drive.contrast_en = st_ff.contrast_en;
	assign drive.contrast = st_ff.contrast;
	assign drive.exp_en = st_ff.disp_mode[lcdc_pkg::LCDC_EXP_BIT];

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	a_all_on_wins: assert property (
		(drive.power && st_ff.disp_mode[lcdc_pkg::LCDC_ALL_ON_BIT]) |=> (&seg_on))
		else $error("all-on did not light every segment");
	a_all_off_blank: assert property (
		(drive.power && st_ff.disp_mode[lcdc_pkg::LCDC_ALL_OFF_BIT]
		&& !st_ff.disp_mode[lcdc_pkg::LCDC_ALL_ON_BIT]) |=> (seg_on == '0))
		else $error("all-off left a segment on");
	a_power_off_idle: assert property (
		!drive.power |=> (com_sel == '0 && seg_on == '0))
		else $error("panel driven while power off");
	a_reset_values: assert property (
		!$past(reset_n) |-> (st_ff.power_duty == 4'h0 && st_ff.disp_mode == 4'h4))
		else $error("control bits wrong after reset");
	a_com_range: assert property (
		(st_ff.com_idx <= last_com) |=> (com_sel >> ($past(last_com) + 5'h01)) == '0)
		else $error("common outside active duty");
	a_com_step: assert property (
		(st_ff.com_idx != $past(st_ff.com_idx) && $past(st_ff.com_idx) <= last_com)
		|-> $past(osc_tick))
		else $error("common advanced without slot end");
	a_page_store: assert property (
		(bus.wr && bus.addr == lcdc_pkg::LCDC_OFS_DISP_MODE)
		|=> drive.exp_en == $past(bus.wdata[3]) ##0
		st_ff.disp_mode[lcdc_pkg::LCDC_PAGE_BIT] == $past(bus.wdata[0]))
		else $error("display mode write not stored");
	a_ext_contrast: assert property (
		ext_supply |=> !drive.contrast_en)
		else $error("contrast active on external supply");
	a_duty_write: assert property (
		(bus.wr && bus.addr == lcdc_pkg::LCDC_OFS_POWER_DUTY && bus.wdata[3])
		|=> (last_com == lcdc_pkg::LCDC_LAST_COM_8))
		else $error("duty 1/8 not selected");
endmodule // lcdc_ctrl

// [lcdc_panel.sv]
`timescale 1ns/1ps
module lcdc_panel (
	// panel clock
	input wire logic core_clk,
	// common and segment lines
	input wire logic [lcdc_pkg::LCDC_COMS-1:0] com_sel,
	input wire logic [lcdc_pkg::LCDC_SEGS-1:0] seg_on,
	// dots seen lit on segment 0, one bit per common
	output logic [lcdc_pkg::LCDC_COMS-1:0] seg0_lit
);
	// glass only reacts while a common is selected, so stale dots keep their last state
	always_ff @(posedge core_clk) begin
		for (int c = 0; c < lcdc_pkg::LCDC_COMS; c++) begin
			if (com_sel[c]) begin
				seg0_lit[c] <= seg_on[0];
			end
		end
	end
endmodule // lcdc_panel

// [tb_lcd_driver_control.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("ERROR at %0t: got %h, expected %h", $time, (a), (b)); end end
module tb_lcd_driver_control;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic ext_supply = 1'b0;
	lcdc_pkg::lcdc_bus_s bus = '0;
	logic [3:0] rdata;
	lcdc_pkg::lcdc_drive_s drive;
	logic [lcdc_pkg::LCDC_COMS-1:0] com_sel;
	logic [lcdc_pkg::LCDC_COMS-1:0] seg0_lit;
	logic [lcdc_pkg::LCDC_SEGS-1:0] seg_on;
	int n_errors = 0;
	int num_checks = 0;
	// segment 0 image, one bit per common
	localparam logic [16:0] PAT = 17'h1a5c3;

	always #2.5 core_clk = ~core_clk;

	lcdc_ctrl #(.OSC_DIV(4)) lcdc_ctrl_inst (.core_clk(core_clk), .reset_n(reset_n), .bus(bus),
		.rdata(rdata), .ext_supply(ext_supply), .drive(drive), .com_sel(com_sel),
		.seg_on(seg_on));
	lcdc_panel lcdc_panel_inst (.core_clk(core_clk), .com_sel(com_sel), .seg_on(seg_on),
		.seg0_lit(seg0_lit));

	task finish_test;
		if (n_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// strobes drop for a full cycle so back-to-back calls never reassign in one step
	task wr(input logic [15:0] a, input logic [3:0] d);
		bus.addr = a;
		bus.wdata = d;
		bus.wr = 1'b1;
		@(negedge core_clk);
		bus.wr = 1'b0;
		@(negedge core_clk);
	endtask

	task rd(input logic [15:0] a, input logic [3:0] exp);
		bus.addr = a;
		bus.rd = 1'b1;
		@(negedge core_clk);
		bus.rd = 1'b0;
		`CHK(rdata, exp)
		@(negedge core_clk);
	endtask

	task wait_com(input int c, input int n, input int lim);
		int i;
		for (i = 0; i < lim && com_sel !== (17'h1 << c); i++) begin
			`CHK(com_sel >> n, 17'h0)
			@(negedge core_clk);
		end
		if (i == lim) begin
			n_errors++;
			finish_test();
		end
	endtask

	// a skipped common, or a repeated one at 1/8, overruns the slot bound and fails
	task scan(input int n, input int base);
		int c;
		wait_com(0, n, 12000);
		for (c = 0; c < n; c++) begin
			wait_com(c, n, 700);
			@(negedge core_clk);
			`CHK(seg_on[0], PAT[base + c])
		end
		wait_com(0, n, 700);
	endtask

	initial begin
		repeat (10) @(negedge core_clk);
		reset_n = 1'b1;
		`CHK(com_sel, 17'h0)
		rd(16'hff60, 4'h0);
		rd(16'hff61, 4'h4);
		rd(16'hff63, 4'h0);
		wr(16'hff62, 4'hf);
		`CHK(drive.contrast, 4'hf)
		wr(16'hff62, 4'h0);
		rd(16'hff62, 4'h0);
		ext_supply = 1'b1;
		repeat (2) @(negedge core_clk);
		`CHK(drive.contrast_en, 1'b0)
		ext_supply = 1'b0;
		repeat (2) @(negedge core_clk);
		`CHK(drive.contrast_en, 1'b1)
		// only populated words are touched
		wr(16'hf000, PAT[3:0]);
		wr(16'hf001, PAT[7:4]);
		wr(16'hf100, PAT[11:8]);
		wr(16'hf101, PAT[15:12]);
		wr(16'hf200, {3'h0, PAT[16]});
		wr(16'hff61, 4'h8);
		`CHK(drive.exp_en, 1'b1)
		wr(16'hff60, 4'h3);
		`CHK(drive.power, 1'b1)
		`CHK(drive.ref_sel, 1'b1)
		// settling time scaled down to cycles; the panel model has no analog level
		repeat (lcdc_pkg::LCDC_SETTLE_MS) @(negedge core_clk);
		scan(17, 0);
		`CHK(seg0_lit, PAT)
		wr(16'hff61, 4'h1);
		rd(16'hff61, 4'h1);
		wr(16'hff60, 4'h5);
		scan(16, 0);
		// shorten the duty while a high common is selected
		wait_com(12, 16, 4000);
		wr(16'hff60, 4'h9);
		scan(8, 8);
		wr(16'hff61, 4'h0);
		wr(16'hff60, 4'hd);
		scan(8, 0);
		wr(16'hff61, 4'h2);
		@(negedge core_clk);
		`CHK(seg_on, {lcdc_pkg::LCDC_SEGS{1'b1}})
		wr(16'hff61, 4'h6);
		@(negedge core_clk);
		`CHK(seg_on, {lcdc_pkg::LCDC_SEGS{1'b1}})
		wr(16'hff61, 4'h4);
		@(negedge core_clk);
		`CHK(seg_on, {lcdc_pkg::LCDC_SEGS{1'b0}})
		rd(16'hf000, PAT[3:0]);
		wr(16'hff60, 4'h0);
		@(negedge core_clk);
		`CHK(com_sel, 17'h0)
		`CHK(drive.power, 1'b0)
		wr(16'hff60, 4'he);
		wr(16'hff61, 4'hb);
		wr(16'hff62, 4'h7);
		reset_n = 1'b0;
		repeat (2) @(negedge core_clk);
		reset_n = 1'b1;
		rd(16'hff60, 4'h0);
		rd(16'hff61, 4'h4);
		rd(16'hff62, 4'h7);
		rd(16'hf000, PAT[3:0]);
		finish_test();
	end
endmodule // tb_lcd_driver_control
